/* File: hw/pmcr_pkg.sv */
// Purpose: Shared constants for the transceiver miscellaneous configuration bank.
// Assumes: 16-bit management words, device clock at 20 MHz.
// Notes: Offsets are management register addresses.
package pmcr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_EQ_FORCE = 16'h033c;
  localparam logic [15:0] OFS_FB_LIMIT = 16'h033e;
  localparam logic [15:0] OFS_LD_TRIM = 16'h0404;
  localparam logic [15:0] OFS_RX10_GAIN = 16'h040d;
  localparam logic [15:0] OFS_HPF_CTRL = 16'h0416;
  localparam logic [15:0] OFS_BANDGAP = 16'h0429;
  localparam logic [15:0] OFS_GENCFG = 16'h0456;
  localparam logic [15:0] OFS_IND_SRC = 16'h0460;
  localparam logic [15:0] OFS_IO_CTRL = 16'h0461;
  localparam logic [15:0] OFS_BASIC_STATUS = 16'h0001;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_EQ_FORCE = 16'hec00;
  localparam logic [15:0] MSK_EQ_FORCE = 16'h007f;
  localparam logic [15:0] RST_FB_LIMIT = 16'h261e;
  localparam logic [15:0] RST_LD_TRIM = 16'h0080;
  localparam logic [15:0] RST_RX10_GAIN = 16'h0000;
  localparam logic [15:0] MSK_RX10_GAIN = 16'h001f;
  localparam logic [15:0] RST_HPF_CTRL = 16'h0830;
  localparam logic [15:0] MSK_HPF_CTRL = 16'h1fb3;
  localparam logic [15:0] RST_BANDGAP = 16'h0000;
  localparam logic [15:0] MSK_BANDGAP = 16'hff00;
  localparam logic [15:0] RST_GENCFG = 16'h0008;
  localparam logic [15:0] MSK_GENCFG = 16'h0008;
  localparam logic [15:0] RST_IND_SRC = 16'h0010;
  localparam logic [15:0] MSK_IND_SRC = 16'h00f0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FB_LIM_SEL_LSB = 13;
  localparam int FB_LIM_VAL_LSB = 8;
  localparam int FB_MSE_SCALE_BIT = 6;
  localparam int FB_DFE_SCALE_BIT = 5;
  localparam int FB_OFFSET_LSB = 0;
  localparam int LD_BIAS_LSB = 12;
  localparam int LD_CM_LSB = 8;
  localparam int LD_IQ_LSB = 5;
  localparam int HPF_CAL_FRC_BIT = 12;
  localparam int HPF_CAL_LSB = 8;
  localparam int HPF_GAIN_FRC_BIT = 7;
  localparam int HPF_GAIN_LSB = 4;
  localparam int HPF_EN_FRC_BIT = 1;
  localparam int HPF_EN_BIT = 0;
  localparam int BG_LSB = 8;
  localparam int GEN_MIN_GAP_BIT = 3;
  localparam int IND_SRC_LSB = 4;
  localparam logic [4:0] RX10_INVERT_MASK = 5'h08;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 50000;
  localparam int GAP_MIN_PS = 120000;
  localparam int GAP_STD_PS = 200000;
  localparam logic [2:0] GAP_MIN_CYC = 3'((GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [2:0] GAP_STD_CYC = 3'((GAP_STD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // Indicator source codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PMCR_IND_LINK = 4'h0,
    PMCR_IND_ACT = 4'h1,
    PMCR_IND_TX = 4'h2,
    PMCR_IND_RX = 4'h3,
    PMCR_IND_COL = 4'h4,
    PMCR_IND_SPD100 = 4'h5,
    PMCR_IND_SPD10 = 4'h6,
    PMCR_IND_FDX = 4'h7,
    PMCR_IND_LINK_BLINK = 4'h8,
    PMCR_IND_STRETCH = 4'h9,
    PMCR_IND_LINK100FD = 4'ha,
    PMCR_IND_LPI = 4'hb,
    PMCR_IND_MII_ERR = 4'hc,
    PMCR_IND_LINK_LOST = 4'hd,
    PMCR_IND_PRBS = 4'he,
    PMCR_IND_RSVD = 4'hf
  } pmcr_ind_e;

endpackage

/* File: hw/pmcr_indicator.sv */
// Purpose: Indicator source multiplexer with latched link-lost and test-error sources.
// Assumes: All status inputs are synchronous to clk.
// Notes: Blink and stretch periods are parameters.
`timescale 1ns/1ps
module pmcr_indicator import pmcr_pkg::*; #(
  parameter int BLINK_CYC = 2000000,
  parameter int STRETCH_CYC = 1000000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [3:0] sel,
  input wire logic link_up,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic lpi_active,
  input wire logic mii_err,
  input wire logic prbs_err,
  input wire logic prbs_cnt_clr,
  input wire logic status_read,
  output logic ind
);

  logic link_q, link_d;
  logic lost_q, lost_d;
  logic prbs_q, prbs_d;
  logic [31:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  logic [31:0] str_cnt_q, str_cnt_d;
  logic act;
  logic ind_d;

  assign act = rx_act | tx_act;

  always_comb begin
    link_d = link_up;
    // Set beats a clear in the same cycle so no loss event is missed.
    lost_d = (lost_q & ~status_read) | (link_q & ~link_up); // see RULE_04
    prbs_d = (prbs_q & ~prbs_cnt_clr) | prbs_err; // see RULE_05
    blink_cnt_d = blink_cnt_q + 32'h1;
    blink_d = blink_q;
    if (blink_cnt_q >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_d = 32'h0;
      blink_d = ~blink_q;
    end
    str_cnt_d = (str_cnt_q != 32'h0) ? str_cnt_q - 32'h1 : 32'h0;
    if (act) begin
      str_cnt_d = 32'(STRETCH_CYC);
    end
    case (pmcr_ind_e'(sel)) // see RULE_02
      PMCR_IND_LINK: ind_d = link_up;
      PMCR_IND_ACT: ind_d = act;
      PMCR_IND_TX: ind_d = tx_act;
      PMCR_IND_RX: ind_d = rx_act;
      PMCR_IND_COL: ind_d = collision;
      PMCR_IND_SPD100: ind_d = link_up & speed_100;
      PMCR_IND_SPD10: ind_d = link_up & ~speed_100;
      PMCR_IND_FDX: ind_d = full_duplex;
      PMCR_IND_LINK_BLINK: ind_d = link_up & ~(act & blink_q); // see RULE_03
      PMCR_IND_STRETCH: ind_d = act | (str_cnt_q != 32'h0); // see RULE_03
      PMCR_IND_LINK100FD: ind_d = link_up & speed_100 & full_duplex; // see RULE_03
      PMCR_IND_LPI: ind_d = lpi_active; // see RULE_03
      PMCR_IND_MII_ERR: ind_d = mii_err; // see RULE_03
      PMCR_IND_LINK_LOST: ind_d = lost_d; // see RULE_04
      PMCR_IND_PRBS: ind_d = prbs_d; // see RULE_05
      default: ind_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_q <= 1'b0;
      lost_q <= 1'b0;
      prbs_q <= 1'b0;
      blink_cnt_q <= 32'h0;
      blink_q <= 1'b0;
      str_cnt_q <= 32'h0;
      ind <= 1'b0;
    end else if (ce) begin
      link_q <= link_d;
      lost_q <= lost_d;
      prbs_q <= prbs_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      str_cnt_q <= str_cnt_d;
      ind <= ind_d;
    end
  end

endmodule

/* File: hw/pmcr_bank.sv */
// Purpose: Miscellaneous configuration register bank of an Ethernet transceiver.
// Assumes: Management access arrives as a parallel word port on the device clock.
// Notes: Analog trim words are storage only and are driven out to the analog blocks.
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Gap enable set gives a 120 ns gap, clear gives 0.20 us.
// RULE_02 - Indicator codes 0 to 7 pick link, activity, speed, collision, duplex sources.
// RULE_03 - Codes 8 to 0xC pick blink, stretch, 100FD, low power, error; 0xF reserved.
// RULE_04 - Code 0xD latches link loss until the basic status word is read.
// RULE_05 - Code 0xE latches any test pattern error until its counter clears.
// RULE_06 - Feedback coefficient magnitude clamps to the limit value per limit select.
// RULE_07 - Error threshold scales with amplifier setting only when its enable is set.
// RULE_08 - Feedback threshold scales with amplifier setting when its enable is set.
// RULE_09 - Offset is added to amplifier attenuation before scaling both thresholds.
// RULE_10 - Ten meg comparator gain steps 25 mV from 200 mV; bit 3 inverted.
// RULE_11 - Line driver word splits into bias, common mode debug and current fields.
// RULE_12 - Each filter override bit selects the register value over the internal one.
module pmcr_bank import pmcr_pkg::*; #(
  parameter int BLINK_CYC = 2000000,
  parameter int STRETCH_CYC = 1000000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit_q,
  input wire logic link_up,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic lpi_active,
  input wire logic mii_err,
  input wire logic prbs_err,
  input wire logic prbs_cnt_clr,
  output logic indicator,
  output logic [2:0] gap_cycles,
  input wire logic signed [7:0] dfe_coeff_raw,
  output logic signed [7:0] dfe_coeff_lim,
  input wire logic [4:0] pga_atten,
  input wire logic [7:0] mse_th_base,
  input wire logic [7:0] dfe_th_base,
  output logic [7:0] mse_th,
  output logic [7:0] dfe_th,
  output logic [6:0] deq_coeff_force,
  output logic [4:0] rx10_gain_eff,
  output logic [9:0] rx10_level_mv,
  output logic [3:0] ld_bias,
  output logic [3:0] ld_cm_debug,
  output logic [2:0] ld_current_sel,
  input wire logic hpf_en_auto,
  input wire logic [1:0] hpf_gain_auto,
  input wire logic [3:0] hpf_cal_auto,
  output logic hpf_en,
  output logic [1:0] hpf_gain,
  output logic [3:0] hpf_cal,
  output logic [7:0] bandgap_trim_val
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] eq_q, eq_d, fb_q, fb_d, ld_q, ld_d, rx10_q, rx10_d;
  logic [15:0] hpf_q, hpf_d, bg_q, bg_d, gen_q, gen_d, ind_q, ind_d;
  logic [15:0] rdata_d;
  logic hit_d;
  logic status_read;

  // Only the writable bits in each mask take a write, so the other bits keep their reset value.
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] msk,
                                         input logic [15:0] wd);
    wmerge = (old & ~msk) | (wd & msk);
  endfunction

  always_comb begin
    eq_d = eq_q;
    fb_d = fb_q;
    ld_d = ld_q;
    rx10_d = rx10_q;
    hpf_d = hpf_q;
    bg_d = bg_q;
    gen_d = gen_q;
    ind_d = ind_q;
    if (reg_wr) begin
      case (reg_addr)
        OFS_EQ_FORCE: eq_d = wmerge(eq_q, MSK_EQ_FORCE, reg_wdata);
        OFS_FB_LIMIT: fb_d = reg_wdata;
        OFS_LD_TRIM: ld_d = reg_wdata;
        OFS_RX10_GAIN: rx10_d = wmerge(rx10_q, MSK_RX10_GAIN, reg_wdata);
        OFS_HPF_CTRL: hpf_d = wmerge(hpf_q, MSK_HPF_CTRL, reg_wdata);
        OFS_BANDGAP: bg_d = wmerge(bg_q, MSK_BANDGAP, reg_wdata);
        OFS_GENCFG: gen_d = wmerge(gen_q, MSK_GENCFG, reg_wdata);
        OFS_IND_SRC: ind_d = wmerge(ind_q, MSK_IND_SRC, reg_wdata);
        default: ;
      endcase
    end
    hit_d = 1'b1;
    case (reg_addr)
      OFS_EQ_FORCE: rdata_d = eq_q;
      OFS_FB_LIMIT: rdata_d = fb_q;
      OFS_LD_TRIM: rdata_d = ld_q;
      OFS_RX10_GAIN: rdata_d = rx10_q;
      OFS_HPF_CTRL: rdata_d = hpf_q;
      OFS_BANDGAP: rdata_d = bg_q;
      OFS_GENCFG: rdata_d = gen_q;
      OFS_IND_SRC: rdata_d = ind_q;
      OFS_IO_CTRL: rdata_d = 16'h0000;
      default: begin
        rdata_d = 16'h0000;
        hit_d = 1'b0;
      end
    endcase
    if (!reg_rd) begin
      rdata_d = reg_rdata;
      hit_d = reg_hit_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eq_q <= RST_EQ_FORCE;
      fb_q <= RST_FB_LIMIT;
      ld_q <= RST_LD_TRIM;
      rx10_q <= RST_RX10_GAIN;
      hpf_q <= RST_HPF_CTRL;
      bg_q <= RST_BANDGAP;
      gen_q <= RST_GENCFG;
      ind_q <= RST_IND_SRC;
      reg_rdata <= 16'h0000;
      reg_hit_q <= 1'b0;
    end else if (ce) begin
      eq_q <= eq_d;
      fb_q <= fb_d;
      ld_q <= ld_d;
      rx10_q <= rx10_d;
      hpf_q <= hpf_d;
      bg_q <= bg_d;
      gen_q <= gen_d;
      ind_q <= ind_d;
      reg_rdata <= rdata_d;
      reg_hit_q <= hit_d;
    end
  end

  // ----------------------------------------------------------------
  // Indicator source
  // ----------------------------------------------------------------
  assign status_read = reg_rd & (reg_addr == OFS_BASIC_STATUS); // see RULE_04

  pmcr_indicator #(
    .BLINK_CYC(BLINK_CYC),
    .STRETCH_CYC(STRETCH_CYC)
  ) u_ind (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .sel(ind_q[IND_SRC_LSB +: 4]),
    .link_up(link_up),
    .rx_act(rx_act),
    .tx_act(tx_act),
    .collision(collision),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .lpi_active(lpi_active),
    .mii_err(mii_err),
    .prbs_err(prbs_err),
    .prbs_cnt_clr(prbs_cnt_clr),
    .status_read(status_read),
    .ind(indicator)
  );

  // ----------------------------------------------------------------
  // Datapath settings
  // ----------------------------------------------------------------
  logic [1:0] lim_sel;
  logic [4:0] lim_val;
  logic [7:0] mag;
  logic [7:0] mag_lim;
  logic [5:0] level;
  logic [13:0] mse_prod, dfe_prod;
  logic [7:0] mse_th_d, dfe_th_d, coeff_d;

  assign lim_sel = fb_q[FB_LIM_SEL_LSB +: 2];
  assign lim_val = fb_q[FB_LIM_VAL_LSB +: 5];
  assign level = {1'b0, pga_atten} + {1'b0, fb_q[FB_OFFSET_LSB +: 5]}; // see RULE_09
  assign mse_prod = 14'(mse_th_base * level);
  assign dfe_prod = 14'(dfe_th_base * level);

  always_comb begin
    mag = dfe_coeff_raw[7] ? 8'(-dfe_coeff_raw) : 8'(dfe_coeff_raw);
    mag_lim = mag;
    // Select zero leaves the coefficient free; any other select enforces the limit.
    if (lim_sel != 2'h0 && mag > {3'h0, lim_val}) begin
      mag_lim = {3'h0, lim_val}; // see RULE_06
    end
    coeff_d = dfe_coeff_raw[7] ? 8'(-mag_lim) : mag_lim;
    mse_th_d = fb_q[FB_MSE_SCALE_BIT] ? mse_prod[12:5] : mse_th_base; // see RULE_07
    dfe_th_d = fb_q[FB_DFE_SCALE_BIT] ? dfe_prod[12:5] : dfe_th_base; // see RULE_08
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dfe_coeff_lim <= 8'sh00;
      mse_th <= 8'h00;
      dfe_th <= 8'h00;
      gap_cycles <= GAP_MIN_CYC;
    end else if (ce) begin
      dfe_coeff_lim <= signed'(coeff_d);
      mse_th <= mse_th_d;
      dfe_th <= dfe_th_d;
      gap_cycles <= gen_q[GEN_MIN_GAP_BIT] ? GAP_MIN_CYC : GAP_STD_CYC; // see RULE_01
    end
  end

  // Trim words come straight from flip-flops; the ten meg outputs pass through logic and the filter outputs take the unregistered auto inputs unless overridden.
  assign deq_coeff_force = eq_q[6:0];
  assign rx10_gain_eff = rx10_q[4:0] ^ RX10_INVERT_MASK; // see RULE_10
  assign rx10_level_mv = 10'd200 + 10'(rx10_q[4:0] * 5'd25); // see RULE_10
  assign ld_bias = ld_q[LD_BIAS_LSB +: 4]; // see RULE_11
  assign ld_cm_debug = ld_q[LD_CM_LSB +: 4]; // see RULE_11
  assign ld_current_sel = ld_q[LD_IQ_LSB +: 3]; // see RULE_11
  assign hpf_en = hpf_q[HPF_EN_FRC_BIT] ? hpf_q[HPF_EN_BIT] : hpf_en_auto; // see RULE_12
  assign hpf_gain = hpf_q[HPF_GAIN_FRC_BIT] ? hpf_q[HPF_GAIN_LSB +: 2] : hpf_gain_auto; // see RULE_12
  assign hpf_cal = hpf_q[HPF_CAL_FRC_BIT] ? hpf_q[HPF_CAL_LSB +: 4] : hpf_cal_auto; // see RULE_12
  assign bandgap_trim_val = bg_q[BG_LSB +: 8];

endmodule

/* File: bench/pmcr_bank_monitor.sv */
// Purpose: Concurrent checks on the configuration bank ports.
// Assumes: Single clock domain, indicator code shadowed from observed writes.
// Notes: Clamp and threshold arithmetic is left to the bench comparisons.
`timescale 1ns/1ps
module pmcr_bank_monitor import pmcr_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit_q,
  input wire logic link_up,
  input wire logic tx_act,
  input wire logic prbs_err,
  input wire logic indicator,
  input wire logic [2:0] gap_cycles,
  input wire logic [4:0] rx10_gain_eff,
  input wire logic [9:0] rx10_level_mv
);
  // ----------------------------------------------------------------
  // Shadow of the indicator code
  // ----------------------------------------------------------------
  // Writes to the code are excluded from the antecedents, because the output
  // may legally follow either code on the edge where the code changes.
  logic [3:0] sel_d, sel_q;
  logic ind_wr;
  assign ind_wr = ce && reg_wr && reg_addr == OFS_IND_SRC;
  always_comb begin
    sel_d = sel_q;
    if (ind_wr) begin
      sel_d = reg_wdata[7:4];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= 4'h1;
    end else begin
      sel_q <= sel_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_gap_from_enable: assert property ((ce && reg_wr && reg_addr == OFS_GENCFG) ##1
    (ce && !(reg_wr && reg_addr == OFS_GENCFG)) |=>
    gap_cycles == ($past(reg_wdata[3], 2) ? 3'h3 : 3'h4))
    else $error("gap cycles do not follow the gap enable");
  a_link_code: assert property (sel_q == 4'h0 && ce && !ind_wr |=> indicator == $past(link_up))
    else $error("indicator does not follow link");
  a_tx_code: assert property (sel_q == 4'h2 && ce && !ind_wr |=> indicator == $past(tx_act))
    else $error("indicator does not follow transmit activity");
  a_reserved_code_low: assert property (sel_q == 4'hf && ce && !ind_wr |=> !indicator)
    else $error("reserved code drives the indicator");
  a_link_lost_set: assert property (sel_q == 4'hd && ce && !ind_wr && $fell(link_up) |=> indicator)
    else $error("link loss not shown");
  a_link_lost_hold: assert property (sel_q == 4'hd && indicator && !ind_wr &&
    $past(sel_q) == 4'hd && !(reg_rd && reg_addr == OFS_BASIC_STATUS) |=> indicator)
    else $error("link loss dropped before status read");
  a_prbs_err_set: assert property (sel_q == 4'he && ce && !ind_wr && prbs_err |=> indicator)
    else $error("test pattern error not shown");
  a_rx10_level_map: assert property (rx10_level_mv == 10'(200 + 25 * (rx10_gain_eff ^ RX10_INVERT_MASK)))
    else $error("comparator level does not match gain field");
  a_status_read_zero: assert property (ce && reg_rd && reg_addr == OFS_BASIC_STATUS |=>
    reg_rdata == 16'h0000 && !reg_hit_q)
    else $error("status address read not refused");
  a_rdata_holds: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule
bind pmcr_bank pmcr_bank_monitor i_mon (.*);

/* File: bench/pmcr_bank_tb_top.sv */
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Latencies as handed over; blink and stretch counts shortened.
// Notes: Blink is judged by a count over one full period, so its free-running phase does not matter.
`timescale 1ns/1ps
module pmcr_bank_tb_top;
  import pmcr_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic prbs_err = 1'b0, prbs_cnt_clr = 1'b0, hpf_en_auto, reg_hit_q, indicator, hpf_en;
  logic link_up, rx_act, tx_act, collision, speed_100, full_duplex, lpi_active, mii_err;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic signed [7:0] dfe_coeff_raw = 8'sh00, dfe_coeff_lim;
  logic [4:0] pga_atten = 5'h00, rx10_gain_eff;
  logic [7:0] mse_th_base = 8'h40, dfe_th_base = 8'h40, mse_th, dfe_th, bandgap_trim_val;
  logic [7:0] st = 8'h00;
  logic [6:0] ha = 7'h00, deq_coeff_force;
  logic [1:0] hpf_gain_auto, hpf_gain;
  logic [3:0] hpf_cal_auto, hpf_cal, ld_bias, ld_cm_debug;
  logic [2:0] gap_cycles, ld_current_sel;
  logic [9:0] rx10_level_mv;
  int mismatches = 0, samples_checked = 0;
  logic [15:0] ra [9] = '{OFS_EQ_FORCE, OFS_FB_LIMIT, OFS_LD_TRIM, OFS_RX10_GAIN, OFS_HPF_CTRL,
    OFS_BANDGAP, OFS_GENCFG, OFS_IND_SRC, OFS_IO_CTRL};
  logic [15:0] rv [9] = '{RST_EQ_FORCE, RST_FB_LIMIT, RST_LD_TRIM, RST_RX10_GAIN, RST_HPF_CTRL,
    RST_BANDGAP, RST_GENCFG, RST_IND_SRC, 16'h0000};
  logic [15:0] rm [9] = '{MSK_EQ_FORCE, 16'hffff, 16'hffff, MSK_RX10_GAIN, MSK_HPF_CTRL,
    MSK_BANDGAP, MSK_GENCFG, MSK_IND_SRC, 16'h0000};
  logic [7:0] pats [4] = '{8'ha5, 8'h5a, 8'hc3, 8'hbc};
  assign {link_up, rx_act, tx_act, collision, speed_100, full_duplex, lpi_active, mii_err} = st;
  assign {hpf_en_auto, hpf_gain_auto, hpf_cal_auto} = ha;
  always #25 clk = ~clk;
  pmcr_bank #(.BLINK_CYC(8), .STRETCH_CYC(4)) i_dut (.*);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic f_ind(input logic [3:0] c, input logic [7:0] s);
    case (c)
      4'h0: return s[7];
      4'h1: return s[6] | s[5];
      4'h2: return s[5];
      4'h3: return s[6];
      4'h4: return s[4];
      4'h5: return s[7] & s[3];
      4'h6: return s[7] & ~s[3];
      4'h7: return s[2];
      4'ha: return s[7] & s[3] & s[2];
      4'hb: return s[1];
      4'hc: return s[0];
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic h);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
    chk("reg_hit_q", {15'h0000, h}, {15'h0000, reg_hit_q});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i], 1'b1);
    wr(16'h0462, 16'hffff);
    rd(16'h0462, 16'h0000, 1'b0);
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], 16'hffff);
      rd(ra[i], rv[i] | rm[i], 1'b1);
      wr(ra[i], 16'h0000);
      rd(ra[i], rv[i] & ~rm[i], 1'b1);
    end
  endtask
  task automatic t_fields();
    wr(OFS_LD_TRIM, 16'ha5c0);
    wr(OFS_RX10_GAIN, 16'h0005);
    wr(OFS_BANDGAP, 16'h3c00);
    wr(OFS_EQ_FORCE, 16'h0055);
    cyc(1);
    chk("ld_fields", 16'h052e, {5'h00, ld_bias, ld_cm_debug, ld_current_sel});
    chk("rx10_eff", 16'h000d, {11'h000, rx10_gain_eff});
    chk("rx10_mv", 16'h0145, {6'h00, rx10_level_mv});
    chk("bandgap", 16'h003c, {8'h00, bandgap_trim_val});
    chk("deq_force", 16'h0055, {9'h000, deq_coeff_force});
    chk("gap_std", 16'h0004, {13'h0000, gap_cycles});
    wr(OFS_GENCFG, 16'h0008);
    cyc(1);
    chk("gap_min", 16'h0003, {13'h0000, gap_cycles});
  endtask
  task automatic t_datapath();
    wr(OFS_FB_LIMIT, 16'h2642);
    @(posedge clk);
    pga_atten <= 5'h03;
    dfe_coeff_raw <= 8'sh64;
    cyc(2);
    chk("lim_pos", 16'h0006, {8'h00, $unsigned(dfe_coeff_lim)});
    chk("mse_scaled", 16'h000a, {8'h00, mse_th});
    chk("dfe_plain", 16'h0040, {8'h00, dfe_th});
    @(posedge clk);
    dfe_coeff_raw <= 8'sh9c;
    cyc(2);
    chk("lim_neg", 16'h00fa, {8'h00, $unsigned(dfe_coeff_lim)});
    wr(OFS_FB_LIMIT, 16'h003e);
    @(posedge clk);
    pga_atten <= 5'h1f;
    cyc(2);
    chk("lim_off", 16'h009c, {8'h00, $unsigned(dfe_coeff_lim)});
    chk("dfe_scaled", 16'h007a, {8'h00, dfe_th});
    chk("mse_plain", 16'h0040, {8'h00, mse_th});
  endtask
  task automatic t_hpf();
    @(posedge clk);
    ha <= 7'h55;
    cyc(2);
    chk("hpf_auto", 16'h0055, {9'h000, hpf_en, hpf_gain, hpf_cal});
    wr(OFS_HPF_CTRL, 16'h1aa2);
    cyc(1);
    chk("hpf_forced", 16'h002a, {9'h000, hpf_en, hpf_gain, hpf_cal});
  endtask
  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      if (c inside {8, 9, 13, 14}) continue;
      wr(OFS_IND_SRC, 16'(c << 4));
      foreach (pats[k]) begin
        @(posedge clk);
        st <= pats[k];
        cyc(2);
        chk("indicator", {15'h0000, f_ind(4'(c), pats[k])}, {15'h0000, indicator});
      end
    end
  endtask
  task automatic t_latches();
    wr(OFS_IND_SRC, 16'h00d0);
    @(posedge clk);
    st <= 8'h80;
    cyc(2);
    rd(OFS_BASIC_STATUS, 16'h0000, 1'b0);
    chk("lost_idle", 16'h0000, {15'h0000, indicator});
    @(posedge clk);
    st <= 8'h00;
    cyc(6);
    chk("lost_held", 16'h0001, {15'h0000, indicator});
    rd(OFS_BASIC_STATUS, 16'h0000, 1'b0);
    chk("lost_clear", 16'h0000, {15'h0000, indicator});
    wr(OFS_IND_SRC, 16'h00e0);
    @(posedge clk);
    prbs_err <= 1'b1;
    @(posedge clk);
    prbs_err <= 1'b0;
    cyc(6);
    chk("prbs_held", 16'h0001, {15'h0000, indicator});
    @(posedge clk);
    prbs_cnt_clr <= 1'b1;
    @(posedge clk);
    prbs_cnt_clr <= 1'b0;
    cyc(1);
    chk("prbs_clear", 16'h0000, {15'h0000, indicator});
  endtask
  task automatic t_timed_codes();
    logic [15:0] n;
    n = 16'h0000;
    wr(OFS_IND_SRC, 16'h0090);
    @(posedge clk);
    st <= 8'h20;
    @(posedge clk);
    st <= 8'h00;
    cyc(4);
    chk("stretch_on", 16'h0001, {15'h0000, indicator});
    cyc(1);
    chk("stretch_off", 16'h0000, {15'h0000, indicator});
    wr(OFS_IND_SRC, 16'h0080);
    @(posedge clk);
    st <= 8'h80;
    cyc(2);
    chk("blink_idle", 16'h0001, {15'h0000, indicator});
    @(posedge clk);
    st <= 8'ha0;
    cyc(2);
    // Sixteen samples span one full blink period, so half of them are lit.
    repeat (16) begin
      n = n + {15'h0000, indicator};
      cyc(1);
    end
    chk("blink_half", 16'h0008, n);
  endtask
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_GENCFG, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rd(OFS_GENCFG, 16'h0008, 1'b1);
    chk("gap_frozen", 16'h0003, {13'h0000, gap_cycles});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_fields();
    t_datapath();
    t_hpf();
    t_codes();
    t_latches();
    t_timed_codes();
    t_freeze();
    print_verdict();
  end
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule
